// >>> common/brxm_pkg.sv
/*
 * brxm_pkg: constants, carrier structs and shared decode for the bit-error
 * receiver register bank and memory address decoder.
 * assumes: one host port clock domain; all users refer to items as brxm_pkg::name.
 */
package brxm_pkg;
	// ----------------------------------------------------------------
	// widths and address layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 14;
	localparam int DATA_W = 16;
	localparam int NSTREAM = 16;
	localparam int MEM_SEL_BIT = 13;        // high selects memory space
	localparam int STRM_HI = 12;            // stream field a12..a8
	localparam int STRM_LO = 8;
	localparam int CHAN_HI = 7;             // channel field a7..a0

	// ----------------------------------------------------------------
	// register offsets (low nibble selects the stream for start, length and error count)
	// ----------------------------------------------------------------
	localparam logic [13:0] CTRL_OFS = 14'h0000;
	localparam logic [13:0] START_OFS = 14'h0300;
	localparam logic [13:0] LEN_OFS = 14'h0320;
	localparam logic [13:0] ERRC_OFS = 14'h0360;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int START_W = 8;             // start_channel_field 7..0
	localparam int LEN_W = 9;               // length_field 8..0
	localparam int ERRC_W = 16;             // error_count_field 15..0
	localparam int TGT_W = 2;               // memory target, control bits 1..0
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [7:0] START_RST = 8'h00;
	localparam logic [8:0] LEN_RST = 9'h000;
	localparam logic [15:0] ERRC_MAX = 16'hffff;
	localparam logic [14:0] PRBS_SEED = 15'h7fff;

	// ----------------------------------------------------------------
	// memory targets and stream rate codes
	// ----------------------------------------------------------------
	localparam logic [1:0] TGT_DATA = 2'h0;
	localparam logic [1:0] TGT_CONN_LOW = 2'h1;  // connection_word_low
	localparam logic [1:0] TGT_CONN_HIGH = 2'h2; // connection_word_high
	localparam logic [3:0] RATE_2M = 4'h1;
	localparam logic [3:0] RATE_4M = 4'h2;
	localparam logic [3:0] RATE_8M = 4'h3;
	localparam logic [3:0] RATE_16M = 4'h4;
	localparam logic [7:0] CHMAX_2M = 8'h1f;
	localparam logic [7:0] CHMAX_4M = 8'h3f;
	localparam logic [7:0] CHMAX_8M = 8'h7f;
	localparam logic [7:0] CHMAX_16M = 8'hff;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sel;
		logic wr;
		logic rd;
		logic [13:0] addr;
		logic [15:0] wdata;
	} brxm_cpu_req_s;

	typedef struct packed {
		logic valid;
		logic we;
		logic [1:0] target;
		logic [3:0] stream;
		logic [7:0] chan;
		logic [15:0] wdata;
	} brxm_mem_req_s;

	typedef enum logic [1:0] {
		BRXM_IDLE = 2'b00,
		BRXM_MWAIT = 2'b01
	} brxm_state_e;

	// channel usable at the stream's rate; unused rate codes allow none
	function automatic logic chan_ok(input logic [3:0] rate, input logic [7:0] chan);
		case (rate)
			RATE_2M: chan_ok = (chan <= CHMAX_2M);
			RATE_4M: chan_ok = (chan <= CHMAX_4M);
			RATE_8M: chan_ok = (chan <= CHMAX_8M);
			RATE_16M: chan_ok = (chan <= CHMAX_16M);
			default: chan_ok = 1'b0;
		endcase
	endfunction : chan_ok
endpackage : brxm_pkg

// >>> hdl/brxm_ber_chk.sv
/*
 * brxm_ber_chk: one stream's bit-error receiver, prbs compare over a channel
 * window and a saturating 16-bit error count.
 * assumes: chan, bit_vld and bit_in come from switch logic on ref_clk.
 */
`timescale 1ns/10ps
module brxm_ber_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic [7:0] start_chan,
	input wire logic [8:0] length,
	input wire logic [7:0] chan,
	input wire logic bit_vld,
	input wire logic bit_in,
	output logic [15:0] err_cnt_q
);
	logic [14:0] prbs_q, prbs_d;
	logic [15:0] err_cnt_d;
	logic [9:0] win_end;
	logic in_win, cmp, mismatch;

	// ----------------------------------------------------------------
	// window and compare
	// ----------------------------------------------------------------
	// ten bits so start plus length never wraps back into range
	assign win_end = {2'b00, start_chan} + {1'b0, length};
	assign in_win = (chan >= start_chan) && ({2'b00, chan} < win_end);
	assign cmp = bit_vld && in_win;
	assign mismatch = bit_in != prbs_q[14];

	// pattern advances only on compared bits; count saturates
	always_comb begin
		prbs_d = prbs_q;
		err_cnt_d = err_cnt_q;
		if (clear) begin
			prbs_d = brxm_pkg::PRBS_SEED;
			err_cnt_d = '0;
		end else if (cmp) begin
			prbs_d = {prbs_q[13:0], prbs_q[14] ^ prbs_q[13]};
			if (mismatch && err_cnt_q != brxm_pkg::ERRC_MAX) begin
				err_cnt_d = err_cnt_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prbs_q <= brxm_pkg::PRBS_SEED;
			err_cnt_q <= 16'h0000;
		end else begin
			prbs_q <= prbs_d;
			err_cnt_q <= err_cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_err_inc;
		!clear && cmp && mismatch && err_cnt_q != 16'hffff |=> err_cnt_q == $past(err_cnt_q) + 16'h0001;
	endproperty
	a_err_inc: assert property (p_err_inc) else $error("error count missed a mismatch");

	property p_err_hold;
		!clear && !(bit_vld && in_win) |=> $stable(err_cnt_q);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error count moved outside window");
endmodule : brxm_ber_chk

// >>> hdl/brxm_regs.sv
/*
 * brxm_regs: host port register bank and memory decode with sixteen
 * per-stream bit-error receivers.
 * assumes: host strobes are one-cycle pulses synchronous to ref_clk; the
 * memory answers reads with a one-cycle mem_rvalid.
 */
// Function
// - a13 high routes access to memory
// - a13 low decodes as register access
// - control bits 1..0 pick memory target
// - a12..a8 stream, a7..a0 channel
// - 2M uses ch 0-31, 4M ch 0-63
// - 8M uses ch 0-127, 16M 0-255
// - start register per stream, 8-bit field
// - length register per stream, 9-bit field
// - read-only 16-bit error count per stream
`timescale 1ns/10ps
module brxm_regs (
	input wire logic ref_clk,
	input wire logic rst,
	input wire brxm_pkg::brxm_cpu_req_s cpu_req,
	input wire logic [15:0][3:0] stream_rate,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_rvalid,
	input wire logic [7:0] ber_chan,
	input wire logic ber_bit_vld,
	input wire logic [15:0] ber_bit,
	output logic [15:0] cpu_rdata_q,
	output logic cpu_ack_q,
	output logic cpu_busy_q,
	output brxm_pkg::brxm_mem_req_s mem_req_q
);
	brxm_pkg::brxm_state_e state_q, state_d;
	brxm_pkg::brxm_mem_req_s mem_req_d;
	logic [15:0] ctrl_q, ctrl_d;
	logic [7:0] start_q [16];
	logic [7:0] start_d [16];
	logic [8:0] len_q [16];
	logic [8:0] len_d [16];
	logic [15:0] clr_q, clr_d;
	logic [15:0] errc [16];
	logic [15:0] cpu_rdata_d, reg_rdata;
	logic cpu_ack_d, take, is_mem, mem_ok;
	logic [4:0] strm;
	logic [7:0] chan;
	logic [3:0] ridx;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	assign take = cpu_req.sel && (cpu_req.wr || cpu_req.rd) && state_q == brxm_pkg::BRXM_IDLE;
	assign is_mem = cpu_req.addr[brxm_pkg::MEM_SEL_BIT];
	assign strm = cpu_req.addr[brxm_pkg::STRM_HI:brxm_pkg::STRM_LO];
	assign chan = cpu_req.addr[brxm_pkg::CHAN_HI:0];
	assign ridx = cpu_req.addr[3:0];
	// streams 16..31 and the spare target code are refused, not aliased
	assign mem_ok = !strm[4] && ctrl_q[1:0] != 2'h3
		&& brxm_pkg::chan_ok(stream_rate[strm[3:0]], chan);

	// register read mux; unmapped offsets read zero
	always_comb begin
		reg_rdata = 16'h0000;
		if (cpu_req.addr == brxm_pkg::CTRL_OFS) begin
			reg_rdata = ctrl_q;
		end else if (cpu_req.addr[13:4] == brxm_pkg::START_OFS[13:4]) begin
			reg_rdata = {8'h00, start_q[ridx]};
		end else if (cpu_req.addr[13:4] == brxm_pkg::LEN_OFS[13:4]) begin
			reg_rdata = {7'h00, len_q[ridx]};
		end else if (cpu_req.addr[13:4] == brxm_pkg::ERRC_OFS[13:4]) begin
			reg_rdata = errc[ridx];
		end
	end

	// ----------------------------------------------------------------
	// access sequencer and register writes
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		ctrl_d = ctrl_q;
		start_d = start_q;
		len_d = len_q;
		clr_d = 16'h0000;
		cpu_ack_d = 1'b0;
		cpu_rdata_d = cpu_rdata_q;
		mem_req_d = mem_req_q;
		mem_req_d.valid = 1'b0;
		case (state_q)
			brxm_pkg::BRXM_IDLE: begin
				if (take && is_mem) begin
					if (mem_ok) begin
						mem_req_d.valid = 1'b1;
						mem_req_d.we = cpu_req.wr;
						mem_req_d.target = ctrl_q[1:0];
						mem_req_d.stream = strm[3:0];
						mem_req_d.chan = chan;
						mem_req_d.wdata = cpu_req.wdata;
						// writes are posted, reads wait for the memory
						cpu_ack_d = cpu_req.wr;
						if (!cpu_req.wr) begin
							state_d = brxm_pkg::BRXM_MWAIT;
						end
					end else begin
						cpu_ack_d = 1'b1;
						if (cpu_req.rd) begin
							cpu_rdata_d = 16'h0000;
						end
					end
				end else if (take) begin
					cpu_ack_d = 1'b1;
					if (cpu_req.rd) begin
						cpu_rdata_d = reg_rdata;
					end else if (cpu_req.addr == brxm_pkg::CTRL_OFS) begin
						ctrl_d = cpu_req.wdata;
					end else if (cpu_req.addr[13:4] == brxm_pkg::START_OFS[13:4]) begin
						// upper bits dropped; host keeps them zero
						start_d[ridx] = cpu_req.wdata[brxm_pkg::START_W-1:0];
						clr_d[ridx] = 1'b1;
					end else if (cpu_req.addr[13:4] == brxm_pkg::LEN_OFS[13:4]) begin
						len_d[ridx] = cpu_req.wdata[brxm_pkg::LEN_W-1:0];
						clr_d[ridx] = 1'b1;
					end
				end
			end
			brxm_pkg::BRXM_MWAIT: begin
				if (mem_rvalid) begin
					cpu_ack_d = 1'b1;
					cpu_rdata_d = mem_rdata;
					state_d = brxm_pkg::BRXM_IDLE;
				end
			end
			default: state_d = brxm_pkg::BRXM_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= brxm_pkg::BRXM_IDLE;
			ctrl_q <= brxm_pkg::CTRL_RST;
			for (int i = 0; i < brxm_pkg::NSTREAM; i++) begin
				start_q[i] <= brxm_pkg::START_RST;
				len_q[i] <= brxm_pkg::LEN_RST;
			end
			clr_q <= 16'h0000;
			cpu_ack_q <= 1'b0;
			cpu_busy_q <= 1'b0;
			cpu_rdata_q <= 16'h0000;
			mem_req_q <= '0;
		end else begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			start_q <= start_d;
			len_q <= len_d;
			clr_q <= clr_d;
			cpu_ack_q <= cpu_ack_d;
			cpu_busy_q <= state_d != brxm_pkg::BRXM_IDLE;
			cpu_rdata_q <= cpu_rdata_d;
			mem_req_q <= mem_req_d;
		end
	end

	// ----------------------------------------------------------------
	// per-stream receivers
	// ----------------------------------------------------------------
	// a start or length write restarts that stream's count and pattern
	for (genvar g = 0; g < brxm_pkg::NSTREAM; g++) begin : g_rx
		brxm_ber_chk u_chk (
			.ref_clk(ref_clk),
			.rst(rst),
			.clear(clr_q[g]),
			.start_chan(start_q[g]),
			.length(len_q[g]),
			.chan(ber_chan),
			.bit_vld(ber_bit_vld),
			.bit_in(ber_bit[g]),
			.err_cnt_q(errc[g])
		);
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_mem_route;
		take && is_mem && mem_ok |=> mem_req_q.valid && mem_req_q.we == $past(cpu_req.wr);
	endproperty
	a_mem_route: assert property (p_mem_route) else $error("memory access not forwarded");

	property p_reg_route;
		take && !is_mem |=> !mem_req_q.valid && cpu_ack_q;
	endproperty
	a_reg_route: assert property (p_reg_route) else $error("register access leaked to memory");

	property p_target;
		take && is_mem && mem_ok |=> mem_req_q.target == $past(ctrl_q[1:0]);
	endproperty
	a_target: assert property (p_target) else $error("memory target not from control bits");

	property p_fields;
		take && is_mem && mem_ok |=> mem_req_q.stream == $past(cpu_req.addr[11:8])
			&& mem_req_q.chan == $past(cpu_req.addr[7:0]);
	endproperty
	a_fields: assert property (p_fields) else $error("stream or channel field misplaced");

	property p_range_low;
		take && is_mem && !strm[4] && stream_rate[strm[3:0]] == 4'h1 && chan > 8'h1f |=> !mem_req_q.valid ##1 !cpu_busy_q;
	endproperty
	a_range_low: assert property (p_range_low) else $error("channel beyond 31 accepted at 2M");

	property p_range_high;
		take && is_mem && !strm[4] && ctrl_q[1:0] != 2'h3 && stream_rate[strm[3:0]] == 4'h4 |=> mem_req_q.valid;
	endproperty
	a_range_high: assert property (p_range_high) else $error("16M channel refused");

	property p_start_wr;
		take && cpu_req.wr && cpu_req.addr[13:4] == 10'h030 |=> start_q[$past(ridx)] == $past(cpu_req.wdata[7:0]);
	endproperty
	a_start_wr: assert property (p_start_wr) else $error("start field not stored");

	property p_len_wr;
		take && cpu_req.wr && cpu_req.addr[13:4] == 10'h032 |=> len_q[$past(ridx)] == $past(cpu_req.wdata[8:0]);
	endproperty
	a_len_wr: assert property (p_len_wr) else $error("length field not stored");

	property p_errc_rd;
		take && cpu_req.rd && cpu_req.addr[13:4] == 10'h036 |=> cpu_ack_q && cpu_rdata_q == $past(errc[ridx]);
	endproperty
	a_errc_rd: assert property (p_errc_rd) else $error("error count read wrong");

	property p_rd_wait;
		take && is_mem && mem_ok && cpu_req.rd |=> cpu_busy_q && !cpu_ack_q;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("memory read acknowledged early");
endmodule : brxm_regs

// >>> tb/brxm_mem_model.sv
/*
 * brxm_mem_model: data and connection memory behind the decoder.
 * assumes: lat (1..15) is set by the bench before each read request.
 */
`timescale 1ns/10ps
module brxm_mem_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire brxm_pkg::brxm_mem_req_s mem_req_q,
	input wire logic [3:0] lat,
	output logic [15:0] mem_rdata,
	output logic mem_rvalid
);
	// ---------------------------------------------
	// read answer after lat cycles
	// ---------------------------------------------
	int cnt;
	logic [15:0] pend;

	// data word tells who was asked; the line toggles when idle so stale values never match
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			pend <= 16'h0;
			mem_rvalid <= 1'b0;
			mem_rdata <= 16'h0;
		end else begin
			mem_rvalid <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req_q.valid && !mem_req_q.we) begin
				cnt <= int'(lat);
				pend <= {mem_req_q.stream, mem_req_q.chan, 2'h0, mem_req_q.target};
			end else if (cnt == 1) begin
				mem_rvalid <= 1'b1;
				mem_rdata <= pend;
				cnt <= 0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : brxm_mem_model

// >>> tb/test_brxm_regs.sv
/*
 * test_brxm_regs: self-checking bench for the register bank and memory decode.
 * assumes: brxm_pkg compiled first; host strobes driven on falling edges.
 */
`timescale 1ns/10ps
module test_brxm_regs;
	// ---------------------------------------------
	// signals, queues and instances
	// ---------------------------------------------
	logic ref_clk, rst, mem_rvalid, cpu_ack_q, cpu_busy_q, ber_bit_vld;
	brxm_pkg::brxm_cpu_req_s cpu_req;
	brxm_pkg::brxm_mem_req_s mem_req_q;
	logic [15:0][3:0] stream_rate;
	logic [15:0] mem_rdata, cpu_rdata_q, ber_bit, last_rd, b;
	logic [7:0] ber_chan, mx;
	logic [3:0] lat;
	logic [16:0] ent;
	logic [16:0] rq[$];
	logic [30:0] mq[$];
	int fail_count, total_checks, sum;

	brxm_regs dut (.ref_clk(ref_clk), .rst(rst), .cpu_req(cpu_req), .stream_rate(stream_rate),
		.mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .ber_chan(ber_chan), .ber_bit_vld(ber_bit_vld),
		.ber_bit(ber_bit), .cpu_rdata_q(cpu_rdata_q), .cpu_ack_q(cpu_ack_q), .cpu_busy_q(cpu_busy_q),
		.mem_req_q(mem_req_q));
	brxm_mem_model mem_model (.ref_clk(ref_clk), .rst(rst), .mem_req_q(mem_req_q), .lat(lat),
		.mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	// one host access; strobe held one cycle, then wait for the answer
	task automatic acc(input logic w, input logic [13:0] a, input logic [15:0] d, input logic c,
		input logic [15:0] e);
		int n;
		@(negedge ref_clk);
		cpu_req = '{sel: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
		rq.push_back({c, e});
		n = 0;
		do begin
			@(negedge ref_clk);
			cpu_req.sel = 1'b0;
			cpu_req.wr = 1'b0;
			cpu_req.rd = 1'b0;
			n++;
		end while (cpu_ack_q !== 1'b1 && n < 40);
	endtask : acc

	// pick target, then one memory access; refused ones must not reach memory
	task automatic mem(input logic [1:0] t, input logic [3:0] s, input logic [7:0] ch, input logic ok);
		logic w;
		logic [15:0] d;
		w = 1'($urandom);
		d = 16'($urandom);
		lat = 4'($urandom_range(4, 1));
		acc(1'b1, brxm_pkg::CTRL_OFS, {14'h0, t}, 1'b0, 16'h0);
		if (ok) mq.push_back({w, t, s, ch, w ? d : 16'h0});
		acc(w, {2'b10, s, ch}, d, !w, ok ? {s, ch, 2'h0, t} : 16'h0);
	endtask : mem

	// monitor: oldest note against each answer
	always @(negedge ref_clk) begin
		if (cpu_ack_q === 1'b1) begin
			last_rd = cpu_rdata_q;
			ent = (rq.size() > 0) ? rq.pop_front() : 17'h1ffff;
			if (ent[16]) check("rdata", 32'(cpu_rdata_q), 32'(ent[15:0]));
		end
		if (mem_req_q.valid === 1'b1) begin
			// a forwarded read must hold the port busy, a posted write must not
			check("busy", 32'(cpu_busy_q), 32'((mq.size() > 0) ? !mq[0][30] : 1'b1));
			check("mem_req", 32'(mem_req_q.we ? mem_req_q[30:0] : {mem_req_q[30:16], 16'h0}),
				32'((mq.size() > 0) ? mq.pop_front() : 31'h7fffffff));
		end
	end

	initial begin
		#(50 * 20000);
		fail_count++;
		stop_test();
	end

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		void'($urandom(81067));
		cpu_req = '0;
		stream_rate = {16{brxm_pkg::RATE_16M}};
		ber_bit_vld = 1'b0;
		ber_chan = 8'h0;
		ber_bit = 16'h0;
		lat = 4'h1;
		rst = 1'b1;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		// reset values, then writes with upper bits zero read back, and a read-only count
		for (int i = 0; i < 16; i++) begin
			acc(1'b0, brxm_pkg::START_OFS + 14'(i), 16'h0, 1'b1, 16'h0);
			acc(1'b0, brxm_pkg::ERRC_OFS + 14'(i), 16'h0, 1'b1, 16'h0);
			b = 16'($urandom);
			// host keeps the unused upper bits zero
			acc(1'b1, brxm_pkg::START_OFS + 14'(i), {8'h0, b[7:0]}, 1'b0, 16'h0);
			acc(1'b0, brxm_pkg::START_OFS + 14'(i), 16'h0, 1'b1, {8'h0, b[7:0]});
			acc(1'b1, brxm_pkg::LEN_OFS + 14'(i), {7'h0, b[8:0]}, 1'b0, 16'h0);
			acc(1'b0, brxm_pkg::LEN_OFS + 14'(i), 16'h0, 1'b1, {7'h0, b[8:0]});
			acc(1'b1, brxm_pkg::ERRC_OFS + 14'(i), b, 1'b0, 16'h0);
			acc(1'b0, brxm_pkg::ERRC_OFS + 14'(i), 16'h0, 1'b1, 16'h0);
		end
		acc(1'b0, 14'h0340, 16'h0, 1'b1, 16'h0);
		// channel limit per rate on stream 3, unused rate refuses all
		for (int r = 0; r < 5; r++) begin
			stream_rate[3] = 4'(r);
			mx = (r == 0) ? 8'h0 : 8'((32 << (r - 1)) - 1);
			mem(2'($urandom_range(2, 0)), 4'h3, mx, r != 0);
			if (r > 0 && r < 4) mem(2'($urandom_range(2, 0)), 4'h3, mx + 8'h1, 1'b0);
		end
		for (int i = 0; i < 8; i++) mem(2'($urandom_range(2, 0)), 4'($urandom), 8'($urandom), 1'b1);
		mem(2'h3, 4'h7, 8'h05, 1'b0);
		// back to a legal target so only the stream field can refuse the next read
		acc(1'b1, brxm_pkg::CTRL_OFS, 16'h0, 1'b0, 16'h0);
		acc(1'b0, 14'h3005, 16'h0, 1'b1, 16'h0);
		// streams 5 and 6 see opposite bits: exactly one of them mismatches per compared bit
		for (int s = 5; s < 7; s++) begin
			acc(1'b1, brxm_pkg::START_OFS + 14'(s), 16'h000a, 1'b0, 16'h0);
			acc(1'b1, brxm_pkg::LEN_OFS + 14'(s), 16'h0003, 1'b0, 16'h0);
		end
		repeat (3) @(negedge ref_clk);
		for (int c = 0; c < 21; c++) begin
			b = 16'($urandom);
			b[6] = ~b[5];
			ber_chan = 8'(c);
			ber_bit = b;
			ber_bit_vld = 1'b1;
			@(negedge ref_clk);
			ber_bit_vld = 1'b0;
			@(negedge ref_clk);
		end
		repeat (3) @(negedge ref_clk);
		sum = 0;
		for (int s = 5; s < 7; s++) begin
			acc(1'b0, brxm_pkg::ERRC_OFS + 14'(s), 16'h0, 1'b0, 16'h0);
			@(posedge ref_clk);
			sum += int'(last_rd);
		end
		check("err_sum", 32'(sum), 32'h3);
		check("pending", 32'(rq.size() + mq.size()), 32'h0);
		stop_test();
	end
endmodule : test_brxm_regs
